// File: include/status_bank_pkg.sv
// Constants, register map and types of the fatal and warning status bank
`default_nettype none
package status_bank_pkg;
	// ============================================================
	// Register indices; byte address is four times the index
	localparam logic [7:0] FATAL_STATUS_INDEX = 8'h20;
	localparam logic [7:0] WARNING_STATUS_INDEX = 8'h21;
	localparam logic [7:0] SRQ_TRIGGER_INDEX = 8'h28;
	localparam logic [7:0] FATAL_TRIGGER_INDEX = 8'h29;
	localparam logic [7:0] ALARM_TRIGGER_INDEX = 8'h2a;
	localparam logic [7:0] MODULE_CONTROL_INDEX = 8'h33;
	localparam int BYTE_SHIFT = 2;

	// ============================================================
	// Status word layout
	localparam int SRQ_STATUS_BIT = 15;
	localparam int ALARM_STATUS_BIT = 14;
	localparam int FATAL_SUMMARY_BIT = 13;
	localparam int HW_OFF_STATUS_BIT = 12;
	localparam int NOW_LSB = 8;
	localparam int RUN_FAULT_BIT = 7;
	localparam int LINK_ERROR_BIT = 6;
	localparam int RESTART_BIT = 5;
	localparam int LINK_RESET_BIT = 4;
	localparam logic [7:0] LATCHED_RESET = 8'h30;
	localparam logic [3:0] NOW_RESET = 4'h0;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// ============================================================
	// Trigger word layout
	localparam int TRIG_FATAL_LSB = 0;
	localparam int TRIG_WARN_LSB = 8;
	localparam int TRIG_HW_OFF_BIT = 12;

	// ============================================================
	// Module control word layout
	localparam int CTRL_SOFT_ON_BIT = 0;
	localparam int CTRL_SHUTDOWN_BIT = 1;
	localparam int CTRL_HW_OFF_CHANGED_BIT = 2;

	// ============================================================
	// Bus
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [23:0] ADDR_HIGH_ZERO = 24'h00_0000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_READ = 2'b10
	} bus_state_type;
endpackage
`default_nettype wire

// File: hw/flag_keeper.sv
// Bank of sticky flags, set wins over write-one-to-clear
`timescale 1ns/1ns
`default_nettype none
module flag_keeper #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] set_bits,
	input wire logic [WIDTH-1:0] clear_bits,
	output logic [WIDTH-1:0] flags
);
	// ============================================================
	// Next value
	logic [WIDTH-1:0] next_flags;

	assign next_flags = (flags & ~clear_bits) | set_bits;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= RESET_VALUE;
		end else if (clk_en) begin
			flags <= next_flags;
		end
	end

	// ============================================================
	// Checks
	a_set_beats_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en |=> (($past(set_bits) & ~flags) == '0))
		else $error("set flag lost to clear");

	a_flag_held: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en |=> (($past(flags) & ~$past(clear_bits) & ~flags) == '0))
		else $error("flag dropped without clear");
endmodule
`default_nettype wire

// File: hw/status_bank.sv
// Fatal and warning status registers with triggers and output control
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Latched flags stay set after their cause ends, until host clears them.
// - Fatal word bits 15:8 are read-only live state in fixed order.
// - Fatal word bits 7:0 hold run, link, restart, reset and severe latches.
// - Warning word bits 15:12 match fatal; bits 11:8 hold mild live flags.
// - Warning word bits 7:0 hold run, link, restart, reset and mild latches.
// - Writing one clears a latched bit; zero leaves it alone.
// - Clearing latches drops what they drive, including the service line.
// - A cleared latch whose cause persists sets again and re-drives outputs.
// - Upper byte is live state; writes to it are silently ignored.
// - Lower byte records events since the last clear.
// - Bit 15 reads one while the service request line is low.
// - Bit 14 reads one while the alarm is active.
// - Bit 13 reads one while the fatal summary is active.
// - Bit 12 reads one while the disable pin is low.
// - Pin low clears soft enable; output stays off until host re-enables.
// - A disable pin change can raise the service line if its trigger is set.
// - Shutdown on fatal follows the control register setting.
// - Warning flags never shut the output down.
// - Severe flags come from fatal limit comparisons.
// - Mild flags come from warning limit comparisons.
// - Run fault and link error latch the response byte flags.
// - Restart latch is one after any restart until cleared.
// - Link reset latch sets on a link reset, timeouts included.
// - Latched bits 3:0 are sticky copies of live bits 11:8.
module status_bank (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic hw_output_off_pin_n,
	input wire logic [3:0] severe_now_in,
	input wire logic [3:0] mild_now_in,
	input wire logic run_fault_flag,
	input wire logic link_error_flag,
	input wire logic link_reset_event,
	input wire logic restart_request,
	output logic service_request_line_n,
	output logic alarm_active,
	output logic fatal_active,
	output logic optical_output_on
);
	import status_bank_pkg::*;

	// ============================================================
	// Address decoding helper
	function automatic logic hits(input logic [31:0] addr, input logic [7:0] index);
		hits = (addr[31:8] == ADDR_HIGH_ZERO) && (addr[7:0] == (index << BYTE_SHIFT));
	endfunction

	// ============================================================
	// State
	bus_state_type bus_state;
	bus_state_type next_bus_state;
	logic [31:0] addr_q;
	logic wr_pending;
	logic pin_s1;
	logic pin_s2;
	logic pin_s3;
	logic [15:0] srq_trigger;
	logic [15:0] fatal_trigger;
	logic [15:0] alarm_trigger;
	logic soft_output_on;
	logic shutdown_on_fatal;
	logic [7:0] fatal_latched;
	logic [7:0] warning_latched;
	logic [0:0] hw_off_changed;

	// ============================================================
	// Bus decode
	logic addr_phase;
	logic rd_start;
	logic wr_start;
	logic wr_fatal;
	logic wr_warning;
	logic wr_srq_trig;
	logic wr_fatal_trig;
	logic wr_alarm_trig;
	logic wr_control;
	logic [31:0] read_word;
	logic [31:0] next_hrdata;
	logic next_hreadyout;

	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign rd_start = addr_phase && !hwrite;
	assign wr_start = addr_phase && hwrite;
	assign wr_fatal = wr_pending && hits(addr_q, FATAL_STATUS_INDEX);
	assign wr_warning = wr_pending && hits(addr_q, WARNING_STATUS_INDEX);
	assign wr_srq_trig = wr_pending && hits(addr_q, SRQ_TRIGGER_INDEX);
	assign wr_fatal_trig = wr_pending && hits(addr_q, FATAL_TRIGGER_INDEX);
	assign wr_alarm_trig = wr_pending && hits(addr_q, ALARM_TRIGGER_INDEX);
	assign wr_control = wr_pending && hits(addr_q, MODULE_CONTROL_INDEX);

	// ============================================================
	// Live state and status words
	logic hw_off_status;
	logic hw_off_edge;
	logic [15:0] fatal_word;
	logic [15:0] warning_word;
	logic [15:0] control_word;
	logic [3:0] upper_common;

	assign hw_off_status = !pin_s2;
	assign hw_off_edge = pin_s2 ^ pin_s3;
	assign upper_common = {!service_request_line_n, alarm_active, fatal_active, hw_off_status};
	assign fatal_word = {upper_common, severe_now_in, fatal_latched};
	assign warning_word = {upper_common, mild_now_in, warning_latched};
	assign control_word = {13'h0000, hw_off_changed, shutdown_on_fatal, soft_output_on};

	assign read_word = hits(addr_q, FATAL_STATUS_INDEX) ? {16'h0000, fatal_word}
		: hits(addr_q, WARNING_STATUS_INDEX) ? {16'h0000, warning_word}
		: hits(addr_q, SRQ_TRIGGER_INDEX) ? {16'h0000, srq_trigger}
		: hits(addr_q, FATAL_TRIGGER_INDEX) ? {16'h0000, fatal_trigger}
		: hits(addr_q, ALARM_TRIGGER_INDEX) ? {16'h0000, alarm_trigger}
		: hits(addr_q, MODULE_CONTROL_INDEX) ? {16'h0000, control_word}
		: DATA_ZERO;

	// ============================================================
	// Bus state machine: reads take one wait state
	always_comb begin
		next_bus_state = bus_state;
		next_hrdata = hrdata;
		next_hreadyout = hreadyout;
		case (bus_state)
			BUS_IDLE: begin
				if (rd_start) begin
					next_bus_state = BUS_READ;
					next_hreadyout = 1'b0;
				end
			end
			BUS_READ: begin
				next_bus_state = BUS_IDLE;
				next_hrdata = read_word;
				next_hreadyout = 1'b1;
			end
			default: begin
				next_bus_state = BUS_IDLE;
				next_hreadyout = 1'b1;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= BUS_IDLE;
			hrdata <= DATA_ZERO;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			addr_q <= DATA_ZERO;
			wr_pending <= 1'b0;
		end else if (clk_en) begin
			bus_state <= next_bus_state;
			hrdata <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp <= 1'b0;
			wr_pending <= wr_start;
			if (addr_phase) begin
				addr_q <= haddr;
			end
		end
	end

	// ============================================================
	// Latched flags
	logic [7:0] fatal_set;
	logic [7:0] warning_set;
	logic [7:0] fatal_clear;
	logic [7:0] warning_clear;
	logic [7:0] common_set;
	logic [0:0] hw_off_clear;

	assign common_set = {run_fault_flag, link_error_flag, restart_request, link_reset_event, 4'h0};
	assign fatal_set = common_set | {4'h0, severe_now_in};
	assign warning_set = common_set | {4'h0, mild_now_in};
	// Only the low byte is writable, upper byte writes vanish
	assign fatal_clear = wr_fatal ? hwdata[7:0] : 8'h00;
	assign warning_clear = wr_warning ? hwdata[7:0] : 8'h00;
	assign hw_off_clear = wr_control ? hwdata[CTRL_HW_OFF_CHANGED_BIT] : 1'b0;

	flag_keeper #(.WIDTH(8), .RESET_VALUE(LATCHED_RESET)) fatal_flags (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.set_bits(fatal_set),
		.clear_bits(fatal_clear),
		.flags(fatal_latched)
	);

	flag_keeper #(.WIDTH(8), .RESET_VALUE(LATCHED_RESET)) warning_flags (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.set_bits(warning_set),
		.clear_bits(warning_clear),
		.flags(warning_latched)
	);

	flag_keeper #(.WIDTH(1), .RESET_VALUE(1'b0)) hw_off_flag (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.set_bits(hw_off_edge),
		.clear_bits(hw_off_clear),
		.flags(hw_off_changed)
	);

	// ============================================================
	// Trigger and control registers
	logic next_soft_output_on;

	// Pin low forces the enable off and beats any host write
	assign next_soft_output_on = hw_off_status ? 1'b0
		: wr_control ? hwdata[CTRL_SOFT_ON_BIT]
		: soft_output_on;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			srq_trigger <= WORD_RESET;
			fatal_trigger <= WORD_RESET;
			alarm_trigger <= WORD_RESET;
			soft_output_on <= 1'b0;
			shutdown_on_fatal <= 1'b0;
		end else if (clk_en) begin
			soft_output_on <= next_soft_output_on;
			if (wr_srq_trig) begin
				srq_trigger <= hwdata[15:0];
			end
			if (wr_fatal_trig) begin
				fatal_trigger <= hwdata[15:0];
			end
			if (wr_alarm_trig) begin
				alarm_trigger <= hwdata[15:0];
			end
			if (wr_control) begin
				shutdown_on_fatal <= hwdata[CTRL_SHUTDOWN_BIT];
			end
		end
	end

	// ============================================================
	// Disable pin synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			pin_s3 <= 1'b1;
		end else if (clk_en) begin
			pin_s1 <= hw_output_off_pin_n;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// ============================================================
	// Derived outputs
	logic srq_cause;
	logic alarm_cause;
	logic fatal_cause;
	logic next_output_on;

	assign srq_cause = (|(fatal_latched & srq_trigger[TRIG_FATAL_LSB +: 8]))
		|| (|(warning_latched & srq_trigger[TRIG_WARN_LSB +: 8]))
		|| (hw_off_changed[0] && srq_trigger[TRIG_HW_OFF_BIT]);
	assign fatal_cause = |(fatal_latched & fatal_trigger[TRIG_FATAL_LSB +: 8]);
	assign alarm_cause = (|(fatal_latched & alarm_trigger[TRIG_FATAL_LSB +: 8]))
		|| (|(warning_latched & alarm_trigger[TRIG_WARN_LSB +: 8]));
	// Warning state takes no part in shutdown
	assign next_output_on = soft_output_on && !hw_off_status
		&& !(shutdown_on_fatal && fatal_cause);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			service_request_line_n <= 1'b1;
			alarm_active <= 1'b0;
			fatal_active <= 1'b0;
			optical_output_on <= 1'b0;
		end else if (clk_en) begin
			service_request_line_n <= !srq_cause;
			alarm_active <= alarm_cause;
			fatal_active <= fatal_cause;
			optical_output_on <= next_output_on;
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_read_word_fatal: assert property (
		(clk_en && bus_state == BUS_READ && hits(addr_q, FATAL_STATUS_INDEX))
		|=> (hreadyout && hrdata[15:0] == $past(fatal_word)))
		else $error("fatal word read wrong");

	a_srq_raise: assert property (
		(clk_en && srq_cause) |=> (!service_request_line_n && fatal_word[SRQ_STATUS_BIT]))
		else $error("service line not raised");

	a_srq_release: assert property (
		(clk_en && !srq_cause) |=> service_request_line_n)
		else $error("service line not released");

	a_pin_mirror: assert property (
		(clk_en && !pin_s1) |=> fatal_word[HW_OFF_STATUS_BIT] && warning_word[HW_OFF_STATUS_BIT])
		else $error("disable status does not follow pin");

	a_pin_clears_enable: assert property (
		(clk_en && hw_off_status) |=> (!soft_output_on ##1 !optical_output_on || !clk_en))
		else $error("soft enable survived disable pin");

	a_fatal_shutdown: assert property (
		(clk_en && shutdown_on_fatal && fatal_cause) |=> !optical_output_on)
		else $error("output on during fatal shutdown");

	a_warn_no_shutdown: assert property (
		(clk_en && soft_output_on && !hw_off_status && !(shutdown_on_fatal && fatal_cause))
		|=> optical_output_on)
		else $error("output off without fatal cause");

	a_cause_reasserts: assert property (
		(clk_en && severe_now_in != NOW_RESET) |=> ((fatal_latched[3:0] & $past(severe_now_in)) == $past(severe_now_in)))
		else $error("persisting cause did not relatch");

	a_restart_latch: assert property (
		(clk_en && restart_request) |=> (fatal_latched[RESTART_BIT] && warning_latched[RESTART_BIT]))
		else $error("restart not latched");

	a_upper_ignored: assert property (
		(clk_en && wr_fatal && hwdata[7:0] == 8'h00) |=> (fatal_latched == ($past(fatal_latched) | $past(fatal_set))))
		else $error("upper byte write disturbed latches");
endmodule
`default_nettype wire

// File: bench/status_host.sv
// Host controller model: single word bus transfers
`timescale 1ns/1ns
`default_nettype none
module status_host (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	import status_bank_pkg::*;
	initial begin
		hsel = 1'b0;
		haddr = DATA_ZERO;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = DATA_ZERO;
	end
	// ============================================================
	// Transfer, each phase held until hready
	task automatic xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata, output logic [31:0] rdata,
		output int waits);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		haddr <= ~addr;
		hwdata <= wr ? wdata : ~hwdata;
		waits = -1;
		do begin
			@(posedge hclk);
			waits++;
		end while (hready !== 1'b1);
		rdata = hrdata;
	endtask
endmodule
`default_nettype wire

// File: bench/status_bank_tb.sv
// Self-checking bench of the status bank against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module status_bank_tb;
	import status_bank_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic en = 1'b1;
	logic pin_n = 1'b1;
	logic [3:0] sev = 4'h0;
	logic [3:0] mild = 4'h0;
	logic [3:0] ev = 4'h0;
	wire logic hsel, hwrite, hready, hresp, srq_n, alarm, fatal, out_on;
	wire logic [31:0] haddr, hwdata, hrdata;
	wire logic [1:0] htrans;
	wire logic [2:0] hsize;
	int lat_f = 32'h0000_0030;
	int lat_w = 32'h0000_0030;
	int trg_s = 0;
	int trg_f = 0;
	int trg_a = 0;
	int ctrl = 0;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;

	always #20 hclk = ~hclk;

	status_bank u_status_bank (.hclk(hclk), .hresetn(hresetn), .clk_en(en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .hw_output_off_pin_n(pin_n), .severe_now_in(sev), .mild_now_in(mild),
		.run_fault_flag(ev[3]), .link_error_flag(ev[2]), .link_reset_event(ev[0]), .restart_request(ev[1]),
		.service_request_line_n(srq_n), .alarm_active(alarm), .fatal_active(fatal), .optical_output_on(out_on));

	status_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ============================================================
	// Comparison and reporting
	task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmp_pin(input string what, input logic exp, input logic seen);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic finish_test(input string name);
		$display("test %s finished", name);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ============================================================
	// Model upkeep and bus access
	task automatic settle();
		repeat (4) @(posedge hclk);
		lat_f = lat_f | sev;
		lat_w = lat_w | mild;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
		logic [31:0] r;
		int w;
		host.xfer({ADDR_HIGH_ZERO, idx} << BYTE_SHIFT, 1'b0, DATA_ZERO, r, w);
		cmp_word("read data", {16'h0000, exp}, r);
		cmp_word("read wait states", 32'h0000_0001, 32'(w));
		cmp_pin("response", 1'b0, hresp);
	endtask
	task automatic wr(input logic [7:0] idx, input int d);
		logic [31:0] r;
		int w;
		host.xfer({ADDR_HIGH_ZERO, idx} << BYTE_SHIFT, 1'b1, 32'(d), r, w);
		cmp_word("write wait states", DATA_ZERO, 32'(w));
		if (idx == FATAL_STATUS_INDEX) lat_f = lat_f & ~d & 255;
		if (idx == WARNING_STATUS_INDEX) lat_w = lat_w & ~d & 255;
		if (idx == SRQ_TRIGGER_INDEX) trg_s = d;
		if (idx == FATAL_TRIGGER_INDEX) trg_f = d;
		if (idx == ALARM_TRIGGER_INDEX) trg_a = d;
		if (idx == MODULE_CONTROL_INDEX) ctrl = (d & (pin_n ? 3 : 2)) | (ctrl & 4 & ~d);
		settle();
	endtask
	task automatic pulse(input logic [3:0] p, input logic [3:0] s, input logic [3:0] m);
		ev <= p;
		sev <= s;
		mild <= m;
		@(posedge hclk);
		ev <= 4'h0;
		sev <= 4'h0;
		mild <= 4'h0;
		lat_f = lat_f | (p << 4) | s;
		lat_w = lat_w | (p << 4) | m;
		settle();
	endtask
	task automatic check_all();
		logic f, a, s;
		f = |(lat_f & trg_f & 255);
		a = (|(lat_f & trg_a & 255)) | (|(lat_w & (trg_a >> 8) & 255));
		s = (|(lat_f & trg_s & 255)) | (|(lat_w & (trg_s >> 8) & 255)) | (ctrl[2] & trg_s[12]);
		rd(FATAL_STATUS_INDEX, {s, a, f, ~pin_n, sev, lat_f[7:0]});
		rd(WARNING_STATUS_INDEX, {s, a, f, ~pin_n, mild, lat_w[7:0]});
		cmp_pin("fatal output", f, fatal);
		cmp_pin("alarm output", a, alarm);
		cmp_pin("service line", ~s, srq_n);
		cmp_pin("output enable", ctrl[0] & pin_n & ~(ctrl[1] & f), out_on);
	endtask

	// ============================================================
	// Hang guard
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	// ============================================================
	// Tests
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		void'($urandom(32'h40b2));
		check_all();
		rd(8'h3f, 16'h0000);
		finish_test("reset");
		wr(FATAL_STATUS_INDEX, 32'h0000_ff00);
		check_all();
		wr(FATAL_STATUS_INDEX, 32'h0000_00ff);
		wr(WARNING_STATUS_INDEX, 32'h0000_00ff);
		check_all();
		finish_test("clear");
		for (int i = 0; i < 12; i++) begin
			pulse(4'($urandom), 4'($urandom), 4'($urandom));
			check_all();
			wr(i[0] ? FATAL_STATUS_INDEX : WARNING_STATUS_INDEX, 32'($urandom & 32'h0000_ffff));
			check_all();
		end
		finish_test("random events");
		wr(FATAL_TRIGGER_INDEX, 32'h0000_0001);
		wr(ALARM_TRIGGER_INDEX, 32'h0000_0100);
		wr(SRQ_TRIGGER_INDEX, 32'h0000_0002);
		wr(MODULE_CONTROL_INDEX, 32'h0000_0003);
		wr(FATAL_STATUS_INDEX, 32'h0000_00ff);
		wr(WARNING_STATUS_INDEX, 32'h0000_00ff);
		check_all();
		pulse(4'h0, 4'h1, 4'h1);
		check_all();
		wr(FATAL_STATUS_INDEX, 32'h0000_0001);
		check_all();
		sev <= 4'h2;
		settle();
		check_all();
		wr(FATAL_STATUS_INDEX, 32'h0000_00ff);
		check_all();
		sev <= 4'h0;
		wr(FATAL_STATUS_INDEX, 32'h0000_00ff);
		check_all();
		finish_test("summaries");
		pin_n <= 1'b0;
		ctrl = (ctrl & 6) | 4;
		settle();
		check_all();
		rd(MODULE_CONTROL_INDEX, 16'(ctrl));
		pin_n <= 1'b1;
		ctrl = ctrl | 4;
		settle();
		check_all();
		wr(MODULE_CONTROL_INDEX, 32'h0000_0007);
		check_all();
		rd(MODULE_CONTROL_INDEX, 16'(ctrl));
		wr(SRQ_TRIGGER_INDEX, 32'h0000_1000);
		pin_n <= 1'b0;
		ctrl = (ctrl & 2) | 4;
		settle();
		check_all();
		pin_n <= 1'b1;
		settle();
		check_all();
		wr(MODULE_CONTROL_INDEX, 32'h0000_0004);
		check_all();
		finish_test("disable pin");
		en <= 1'b0;
		sev <= 4'hf;
		ev <= 4'hf;
		repeat (3) @(posedge hclk);
		en <= 1'b1;
		sev <= 4'h0;
		ev <= 4'h0;
		settle();
		check_all();
		finish_test("freeze");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		lat_f = 32'h0000_0030;
		lat_w = 32'h0000_0030;
		trg_s = 0;
		trg_f = 0;
		trg_a = 0;
		ctrl = 0;
		check_all();
		finish_test("restart");
		complete_run();
	end
endmodule
`default_nettype wire
